// ---- common/asp_pkg.sv ----
// constants and types shared by the async serial port and its baud timer
`default_nettype none
package asp_pkg;
  // register byte offsets on the APB
  localparam logic [7:0] SERIAL_CONTROL_OFS = 8'h00;
  localparam logic [7:0] SERIAL_BUFFER_OFS  = 8'h04;
  localparam logic [7:0] TIMER_CONTROL_OFS  = 8'h08;
  localparam logic [7:0] TIMER_RELOAD_OFS   = 8'h0c;
  localparam logic [7:0] INT_STATUS_OFS     = 8'h10;
  localparam logic [7:0] INT_MASK_OFS       = 8'h14;

  // serial_control fields; the two done flags share positions with status and mask
  localparam int FRAME_WIDTH_POS = 7;
  localparam int ADDR_MATCH_POS  = 5;
  localparam int RX_ENABLE_POS   = 4;
  localparam int NINTH_TX_POS    = 3;
  localparam int NINTH_RX_POS    = 2;
  localparam int TX_DONE_POS     = 1;
  localparam int RX_DONE_POS     = 0;

  // timer_control fields
  localparam int TIMER_RUN_POS   = 0;
  localparam int CLK_SEL_LSB     = 1;

  // reset values
  localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
  localparam logic [2:0] TIMER_CONTROL_RST  = 3'h0;
  localparam logic [7:0] TIMER_RELOAD_RST   = 8'h00;
  localparam logic [1:0] INT_MASK_RST       = 2'h0;
  localparam logic [7:0] RX_BUFFER_RST      = 8'h00;

  // timing counts
  localparam logic [5:0] DIV_SYS4   = 6'h04;
  localparam logic [5:0] DIV_SYS12  = 6'h0c;
  localparam logic [5:0] DIV_SYS48  = 6'h30;
  localparam logic [2:0] DIV_EXT8   = 3'h7;
  localparam logic [7:0] TIMER_TOP  = 8'hff;
  localparam logic [3:0] LAST_DATA  = 4'h7;

  typedef enum logic [1:0] {
    CLK_SYS4  = 2'h0,
    CLK_SYS12 = 2'h1,
    CLK_SYS48 = 2'h2,
    CLK_EXT8  = 2'h3
  } asp_clk_sel_t;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_NINTH = 5'h08,
    TX_STOP  = 5'h10
  } asp_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_NINTH = 5'h08,
    RX_STOP  = 5'h10
  } asp_rx_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } asp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } asp_apb_rsp_t;

  typedef struct packed {
    logic       txBit;
    logic       rxSample;
    logic [7:0] lowCount;
  } asp_baud_t;
endpackage
`default_nettype wire

// ---- verilog/asp_baud_timer.sv ----
// auto-reload baud timer with a private receive copy of the low count
`timescale 1ns/1ns
`default_nettype none
module asp_baud_timer (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  timerRun,
  input  wire asp_pkg::asp_clk_sel_t clkSel,
  input  wire logic [7:0]            reloadByte,
  input  wire logic                  extOsc,
  input  wire logic                  rxRestart,
  output asp_pkg::asp_baud_t         baud
);
  import asp_pkg::*;

  typedef struct packed {
    logic [5:0] preCnt;
    logic [2:0] extCnt;
    logic       ext1;
    logic       ext2;
    logic       extPrev;
    logic [7:0] txCount;
    logic [7:0] rxCount;
    logic       txHalf;
    logic       rxHalf;
    logic       txBit;
    logic       rxSample;
  } asp_baud_state_t;

  asp_baud_state_t s, n;
  logic            tick;

  function automatic logic [5:0] divisor(input asp_clk_sel_t sel);
    case (sel)
      CLK_SYS12: divisor = DIV_SYS12;
      CLK_SYS48: divisor = DIV_SYS48;
      default:   divisor = DIV_SYS4;
    endcase
  endfunction

  always_comb begin
    n = s;
    n.txBit = 1'b0;
    n.rxSample = 1'b0;
    n.ext1 = extOsc;
    n.ext2 = s.ext1;
    n.extPrev = s.ext2;
    tick = 1'b0;
    if (!timerRun) begin
      n.preCnt = 6'h00;
      n.extCnt = 3'h0;
    end else if (clkSel == CLK_EXT8) begin
      if (s.ext2 && !s.extPrev) begin
        n.extCnt = s.extCnt + 3'h1;
        tick = (s.extCnt == DIV_EXT8);
      end
    end else if (s.preCnt == divisor(clkSel) - 6'h01) begin
      n.preCnt = 6'h00;
      tick = 1'b1;
    end else begin
      n.preCnt = s.preCnt + 6'h01;
    end
    if (tick) begin
      n.txCount = (s.txCount == TIMER_TOP) ? reloadByte : s.txCount + 8'h01;
      n.rxCount = (s.rxCount == TIMER_TOP) ? reloadByte : s.rxCount + 8'h01;
      if (s.txCount == TIMER_TOP) begin
        n.txHalf = !s.txHalf;
        n.txBit = s.txHalf;
      end
      // first overflow lands mid start bit
      if (s.rxCount == TIMER_TOP) begin
        n.rxHalf = !s.rxHalf;
        n.rxSample = !s.rxHalf;
      end
    end
    if (rxRestart) begin
      n.rxCount = reloadByte;
      n.rxHalf = 1'b0;
      // a stale overflow pulse here would step the receiver half a bit early
      n.rxSample = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // transmit clock from the visible count, receive from the copy
  assign baud = '{txBit: s.txBit, rxSample: s.rxSample, lowCount: s.txCount};

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  restart_reload_a: assert property (rxRestart |=> s.rxCount == $past(reloadByte))
    else $error("receive count not reloaded on start");
  tx_half_div_a: assert property (s.txBit |-> $past(s.txCount) == TIMER_TOP && !s.txHalf)
    else $error("transmit bit tick without second overflow");
endmodule
`default_nettype wire

// ---- verilog/asp_uart.sv ----
// async serial port: APB registers, transmitter, buffered receiver, interrupt
// How it works
// - transmit and receive paths run independently and at the same time
// - a finished byte is buffered so the next frame can shift in
// - serial_buffer reads the received byte, a write loads and starts transmit
// - enabled interrupt rises when either done flag is set
// - done flags stay set until software clears them
// - baud timing comes from the 8-bit auto-reload timer
// - transmit uses the low count, receive a hidden copy of it
// - each counter overflow is halved to give the bit rate
// - receive copy runs with the timer and shares the reload byte
// - a start edge on the receive pin reloads the receive copy
// - timer clock is system clock over 4, 12, 48 or oscillator over 8
// - baud equals timer clock over (256 minus reload), halved
// - 8-bit frame: start, eight data bits LSB first, stop into ninth_rx_bit
// - 9-bit frame adds ninth_tx_bit; received ninth goes to ninth_rx_bit
// - load only if rx flag clear and, with address match, the bit is one
// - frame_width_select, bit 7 of serial_control, picks 8 or 9 bit frames
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module asp_uart (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire asp_pkg::asp_apb_req_t apbReq,
  output asp_pkg::asp_apb_rsp_t      apbRsp,
  input  wire logic                  extOsc,
  input  wire logic                  rxPin,
  output logic                       txPin,
  output logic                       irq
);
  import asp_pkg::*;

  typedef struct packed {
    logic [7:0]    ctrl;
    logic [2:0]    timerCtl;
    logic [7:0]    reload;
    logic [1:0]    flags;
    logic [1:0]    mask;
    logic [7:0]    rxBuf;
    logic [31:0]   prdata;
    logic          pslverr;
    asp_tx_state_t txState;
    logic          txPend;
    logic [7:0]    txShift;
    logic [3:0]    txCnt;
    logic          txOut;
    asp_rx_state_t rxState;
    logic [7:0]    rxShift;
    logic          rxNinth;
    logic [3:0]    rxCnt;
    logic          rx1;
    logic          rx2;
    logic          rxPrev;
  } asp_uart_state_t;

  asp_uart_state_t s, n;
  asp_baud_t       baud;
  logic            setupPh;
  logic            wrAcc;
  logic            bufWr;
  logic            txAccept;
  logic            startDet;
  logic            rxLoad;
  logic            stopBit;
  logic [1:0]      clrFlags;
  logic [1:0]      setFlags;

  // error flag in bit 32, read data below it
  function automatic logic [32:0] regRead(input asp_uart_state_t st,
                                           input logic [7:0] lowCnt,
                                           input logic [7:0] addr);
    case (addr)
      SERIAL_CONTROL_OFS: regRead = {25'h0, st.ctrl[7], 1'b1, st.ctrl[5:2], st.flags};
      // read side returns the buffered byte
      SERIAL_BUFFER_OFS:  regRead = {25'h0, st.rxBuf};
      TIMER_CONTROL_OFS:  regRead = {30'h0, st.timerCtl};
      TIMER_RELOAD_OFS:   regRead = {17'h0, lowCnt, st.reload};
      INT_STATUS_OFS:     regRead = {31'h0, st.flags};
      INT_MASK_OFS:       regRead = {31'h0, st.mask};
      default:            regRead = {1'b1, 32'h0};
    endcase
  endfunction

  asp_baud_timer baudGen (
    .clk        (clk),
    .rst        (rst),
    .timerRun   (s.timerCtl[TIMER_RUN_POS]),
    .clkSel     (asp_clk_sel_t'(s.timerCtl[CLK_SEL_LSB +: 2])),
    .reloadByte (s.reload),
    .extOsc     (extOsc),
    .rxRestart  (startDet),
    .baud       (baud)
  );

  always_comb begin
    setupPh = apbReq.psel && !apbReq.penable;
    // no wait states, so every access phase completes
    wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
    bufWr = wrAcc && apbReq.paddr == SERIAL_BUFFER_OFS;
    // a write while a byte is already waiting would corrupt it, so it is dropped
    txAccept = bufWr && !s.txPend && (s.txState == TX_IDLE || s.txState == TX_STOP);
    // edge seen only on the second synchroniser stage
    startDet = s.ctrl[RX_ENABLE_POS] && s.rxState == RX_IDLE && s.rxPrev && !s.rx2;
    clrFlags = (wrAcc && apbReq.paddr == INT_STATUS_OFS) ? apbReq.pwdata[1:0] : 2'h0;
    stopBit = s.ctrl[FRAME_WIDTH_POS] ? s.rxNinth : s.rx2;
    // overrun and address match both refuse the load
    rxLoad = baud.rxSample && s.rxState == RX_STOP && !s.flags[RX_DONE_POS]
             && (!s.ctrl[ADDR_MATCH_POS] || stopBit);
    setFlags = 2'h0;
    n = s;
    n.rx1 = rxPin;
    n.rx2 = s.rx1;
    n.rxPrev = s.rx2;

    if (setupPh) begin
      {n.pslverr, n.prdata} = regRead(s, baud.lowCount, apbReq.paddr);
    end
    if (wrAcc) begin
      case (apbReq.paddr)
        SERIAL_CONTROL_OFS: begin
          n.ctrl = {apbReq.pwdata[7], 1'b0, apbReq.pwdata[5:3], s.ctrl[NINTH_RX_POS], 2'h0};
        end
        TIMER_CONTROL_OFS: begin
          n.timerCtl = apbReq.pwdata[2:0];
        end
        TIMER_RELOAD_OFS: begin
          n.reload = apbReq.pwdata[7:0];
        end
        INT_MASK_OFS: begin
          n.mask = apbReq.pwdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // write side loads the transmit register
    if (txAccept) begin
      n.txShift = apbReq.pwdata[7:0];
      n.txPend = 1'b1;
    end

    // transmit path, stepped only by the transmit bit tick
    if (baud.txBit) begin
      case (s.txState)
        TX_IDLE, TX_STOP: begin
          if (s.txPend) begin
            n.txState = TX_START;
            n.txOut = 1'b0;
            n.txPend = 1'b0;
          end else begin
            n.txState = TX_IDLE;
            n.txOut = 1'b1;
          end
        end
        TX_START: begin
          n.txState = TX_DATA;
          n.txOut = s.txShift[0];
          n.txShift = {1'b0, s.txShift[7:1]};
          n.txCnt = 4'h0;
        end
        TX_DATA: begin
          if (s.txCnt == LAST_DATA) begin
            // frame width picks the ninth bit
            if (s.ctrl[FRAME_WIDTH_POS]) begin
              n.txState = TX_NINTH;
              n.txOut = s.ctrl[NINTH_TX_POS];
            end else begin
              n.txState = TX_STOP;
              n.txOut = 1'b1;
              setFlags[TX_DONE_POS] = 1'b1;
            end
          end else begin
            n.txCnt = s.txCnt + 4'h1;
            n.txOut = s.txShift[0];
            n.txShift = {1'b0, s.txShift[7:1]};
          end
        end
        TX_NINTH: begin
          n.txState = TX_STOP;
          n.txOut = 1'b1;
          setFlags[TX_DONE_POS] = 1'b1;
        end
        default: begin
          n.txState = TX_IDLE;
          n.txOut = 1'b1;
        end
      endcase
    end

    // start edge arms the receiver and realigns its timer
    if (startDet) begin
      n.rxState = RX_START;
    end else if (baud.rxSample) begin
      case (s.rxState)
        RX_START: begin
          // a start bit gone high at mid bit was a glitch
          n.rxState = s.rx2 ? RX_IDLE : RX_DATA;
          n.rxCnt = 4'h0;
        end
        RX_DATA: begin
          n.rxShift = {s.rx2, s.rxShift[7:1]};
          n.rxCnt = s.rxCnt + 4'h1;
          if (s.rxCnt == LAST_DATA) begin
            n.rxState = s.ctrl[FRAME_WIDTH_POS] ? RX_NINTH : RX_STOP;
          end
        end
        RX_NINTH: begin
          n.rxNinth = s.rx2;
          n.rxState = RX_STOP;
        end
        RX_STOP: begin
          n.rxState = RX_IDLE;
        end
        default: begin
          n.rxState = RX_IDLE;
        end
      endcase
    end

    // shifter and buffer are separate, so the next frame may shift in
    if (rxLoad) begin
      n.rxBuf = s.rxShift;
      n.ctrl[NINTH_RX_POS] = stopBit;
      setFlags[RX_DONE_POS] = 1'b1;
    end

    // flags clear only by software; a same-cycle set wins
    n.flags = (s.flags & ~clrFlags) | setFlags;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{ctrl: SERIAL_CONTROL_RST, timerCtl: TIMER_CONTROL_RST, reload: TIMER_RELOAD_RST,
             mask: INT_MASK_RST, rxBuf: RX_BUFFER_RST, txState: TX_IDLE, txOut: 1'b1,
             rxState: RX_IDLE, rx1: 1'b1, rx2: 1'b1, rxPrev: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign apbRsp = '{prdata: s.prdata, pready: 1'b1, pslverr: s.pslverr};
  assign txPin = s.txOut;
  // level interrupt from unmasked done flags
  assign irq = |(s.flags & s.mask);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  start_bit_low_a: assert property (s.txState == TX_START |-> !txPin)
    else $error("start bit not low");
  ninth_bit_out_a: assert property (s.txState == TX_NINTH |-> txPin == s.ctrl[NINTH_TX_POS])
    else $error("ninth bit differs from control");
  tx_flag_stop_a: assert property ($rose(s.txState == TX_STOP) |-> s.flags[TX_DONE_POS])
    else $error("transmit flag not set at stop");
  flag_sticky_a: assert property (s.flags[RX_DONE_POS] && !clrFlags[RX_DONE_POS]
                                  |=> s.flags[RX_DONE_POS])
    else $error("receive flag dropped without a clear");
  buf_write_a: assert property (txAccept |=> s.txPend ##0 s.txShift == $past(apbReq.pwdata[7:0]))
    else $error("transmit byte not taken");
  rx_no_overwrite_a: assert property (s.flags[RX_DONE_POS] |=> $stable(s.rxBuf))
    else $error("buffer overwritten while flag set");
  frame_mode_a: assert property (s.rxState == RX_NINTH |-> s.ctrl[FRAME_WIDTH_POS])
    else $error("ninth bit phase in 8-bit mode");
  rx_sync_start_a: assert property (startDet |=> s.rxState == RX_START
                                    ##1 s.rxState == RX_START)
    else $error("start edge not followed by start phase");
  irq_raise_a: assert property ($rose(s.flags[RX_DONE_POS]) && s.mask[RX_DONE_POS] |-> irq)
    else $error("receive interrupt missing");

  nine_bit_tx_c: cover property (s.txState == TX_NINTH ##[1:1000] s.flags[TX_DONE_POS]);
  rx_load_c: cover property (rxLoad);
  overrun_c: cover property (baud.rxSample && s.rxState == RX_STOP && s.flags[RX_DONE_POS]);
  both_ways_c: cover property (s.txState == TX_DATA && s.rxState == RX_DATA);
endmodule
`default_nettype wire

// ---- testbench/asp_peer.sv ----
// remote serial transceiver facing the port's transmit and receive pins
`timescale 1ns/1ns
`default_nettype none
module asp_peer #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  input  wire logic txLine,
  output logic      rxLine
);
  integer     gotQ[$];
  logic       nine = 1'b0;
  logic [8:0] v;
  initial rxLine = 1'b1;
  task automatic send(input logic [8:0] d, input logic ninthOn, input logic stopBit);
    logic [10:0] f;
    f = {stopBit, d, 1'b0};
    if (!ninthOn) f[9] = stopBit;
    for (int i = 0; i < (ninthOn ? 11 : 10); i++) begin
      rxLine <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxLine <= 1'b1;
  endtask
  // frames with a low stop bit are reported as -1
  always begin
    @(negedge txLine);
    v = '0;
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      v[i] = txLine;
    end
    repeat (BIT_CLKS) @(posedge clk);
    gotQ.push_back(txLine === 1'b1 ? {23'h0, v} : -1);
  end
endmodule
`default_nettype wire

// ---- testbench/async_serial_port_with_timer_baud_bench.sv ----
// self-checking bench for the async serial port against a queue model
`timescale 1ns/1ns
`default_nettype none
module async_serial_port_with_timer_baud_bench;
  import asp_pkg::*;
  localparam logic [7:0] RLD = 8'hfe;
  // two overflows per bit, clock over 4
  localparam int BITC = 2 * (256 - RLD) * 4;
  logic         clk = 1'b0;
  logic         rst = 1'b0;
  logic         extOsc = 1'b0;
  logic         rxPin;
  logic         txPin;
  logic         irq;
  asp_apb_req_t req = '0;
  asp_apb_rsp_t rsp;
  logic [31:0]  rd;
  logic         err;
  int           err_count = 0;
  int           n_checks = 0;
  int           rxBuf = 0;
  int           rxNin = 0;
  int           rxFlag = 0;
  // timer clock periods in system clocks; the bench oscillator rises every second clock
  int           divs[4] = '{int'(DIV_SYS4), int'(DIV_SYS12), int'(DIV_SYS48),
                            2 * (int'(DIV_EXT8) + 1)};
  always #10 clk = ~clk;
  always @(posedge clk) extOsc <= ~extOsc;
  asp_uart u_dut (.clk(clk), .rst(rst), .apbReq(req), .apbRsp(rsp), .extOsc(extOsc),
                  .rxPin(rxPin), .txPin(txPin), .irq(irq));
  asp_peer #(.BIT_CLKS(BITC)) u_peer (.clk(clk), .txLine(txPin), .rxLine(rxPin));
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo();
    $display("ERROR wait expected done seen timeout");
    err_count++;
    final_report();
  endtask
  task automatic chkReg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic chkSer(input string nm, input integer e, input integer g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (k == 50) tmo();
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic waitStat(input int b);
    int k;
    for (k = 0; k < 400; k++) begin
      apb(1'b0, INT_STATUS_OFS, '0);
      if (rd[b] === 1'b1) break;
    end
    if (k == 400) tmo();
  endtask
  task automatic getTx(input int e);
    int k;
    for (k = 0; k < 400 && u_peer.gotQ.size() == 0; k++) @(posedge clk);
    if (k == 400) tmo();
    chkSer("tx_frame", e, u_peer.gotQ.pop_front());
  endtask
  // load only into a free buffer
  task automatic peerTx(input logic [7:0] d, input logic b, input int m, input int mce);
    @(posedge clk);
    u_peer.send({b, d}, m[0], m ? 1'b1 : b);
    if (rxFlag == 0 && (mce == 0 || b)) begin
      rxBuf = d;
      rxNin = b;
      rxFlag = 1;
    end
  endtask
  initial begin
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] cnt;
    void'($urandom(32'hf48a2642));
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, SERIAL_CONTROL_OFS, '0);
    chkReg("ctl_reset", 32'h40, rd);
    apb(1'b1, 8'h18, 32'hff);
    chkReg("unmapped", 32'h1, 32'(err));
    apb(1'b1, TIMER_RELOAD_OFS, {24'h0, RLD});
    apb(1'b1, TIMER_CONTROL_OFS, 32'h1);
    apb(1'b1, INT_MASK_OFS, 32'h3);
    for (int m = 0; m < 2; m++) begin
      u_peer.nine = m[0];
      for (int mce = 0; mce < 2; mce++) begin
        apb(1'b1, SERIAL_CONTROL_OFS, 32'(m << 7) | 32'(mce << 5) | 32'h18);
        d = 8'($urandom());
        e = 8'($urandom());
        fork
          apb(1'b1, SERIAL_BUFFER_OFS, {24'h0, d});
          peerTx(e, 1'b1, m, mce);
        join
        waitStat(TX_DONE_POS);
        chkReg("irq_tx", 32'h1, 32'(irq));
        getTx(m ? 256 + d : d);
        waitStat(RX_DONE_POS);
        fork
          peerTx(~e, 1'b1, m, mce);
          begin
            apb(1'b0, SERIAL_BUFFER_OFS, '0);
            chkReg("rx_data", rxBuf, rd);
            apb(1'b1, INT_STATUS_OFS, 32'h3);
            rxFlag = 0;
          end
        join
        waitStat(RX_DONE_POS);
        apb(1'b0, SERIAL_BUFFER_OFS, '0);
        chkReg("rx_next", rxBuf, rd);
        apb(1'b0, SERIAL_CONTROL_OFS, '0);
        chkReg("ninth_rx", rxNin, 32'(rd[NINTH_RX_POS]));
        apb(1'b1, INT_STATUS_OFS, 32'h3);
        rxFlag = 0;
        peerTx(e ^ 8'h5a, 1'b0, m, mce);
        repeat (2 * BITC) @(posedge clk);
        peerTx(e ^ 8'ha5, 1'b1, m, mce);
        repeat (BITC) @(posedge clk);
        apb(1'b0, INT_STATUS_OFS, '0);
        chkReg("rx_flag", rxFlag, 32'(rd[RX_DONE_POS]));
        apb(1'b0, SERIAL_BUFFER_OFS, '0);
        chkReg("rx_keep", rxBuf, rd);
        apb(1'b1, INT_STATUS_OFS, 32'h3);
        rxFlag = 0;
      end
    end
    apb(1'b1, INT_MASK_OFS, '0);
    apb(1'b1, SERIAL_BUFFER_OFS, 32'h3c);
    waitStat(TX_DONE_POS);
    @(negedge clk);
    chkReg("irq_masked", 32'h0, 32'(irq));
    apb(1'b1, INT_MASK_OFS, 32'h2);
    @(negedge clk);
    chkReg("irq_unmasked", 32'h1, 32'(irq));
    getTx(256 + 8'h3c);
    apb(1'b1, INT_STATUS_OFS, 32'h2);
    @(negedge clk);
    chkReg("irq_cleared", 32'h0, 32'(irq));
    // count ticks of each timer clock over a 96-clock window
    apb(1'b1, TIMER_RELOAD_OFS, '0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, TIMER_CONTROL_OFS, '0);
      apb(1'b1, TIMER_CONTROL_OFS, 32'(c << 1) | 32'h1);
      apb(1'b0, TIMER_RELOAD_OFS, '0);
      cnt = rd[15:8];
      repeat (93) @(posedge clk);
      apb(1'b0, TIMER_RELOAD_OFS, '0);
      chkReg("timer_rate", 32'(96 / divs[c]), 32'(8'(rd[15:8] - cnt)));
    end
    final_report();
  end
endmodule
`default_nettype wire
